/* File: inc/can_xcvr_pkg.sv */
// Constants, types and register map of the CAN transceiver mode control
package can_xcvr_pkg;

   // Core clock and internal timebase
   localparam int unsigned CLK_PERIOD_NS = 50;    // 20 MHz core clock
   localparam int unsigned TICK_NS = 1000;        // Timebase period, 1 us
   localparam int unsigned TICK_CYCLES =
      (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // Rounded up
   localparam int unsigned TICK_W = 8;            // Divider counter width

   // Timeouts in microseconds (plain defaults)
   localparam int unsigned SILENCE_US = 1000000;  // Bus silence timeout
   localparam int unsigned WAKE_WINDOW_US = 1000; // Wake window timeout
   localparam int unsigned WAKE_DOM_US = 1;       // Least dominant phase
   localparam int unsigned WAKE_REC_US = 1;       // Least recessive phase
   localparam int unsigned TXD_DOM_US = 1000;     // Transmit dominant limit

   // Same timeouts as timebase ticks
   localparam int unsigned SILENCE_TICKS = SILENCE_US * 1000 / TICK_NS;
   localparam int unsigned WAKE_WINDOW_TICKS =
      WAKE_WINDOW_US * 1000 / TICK_NS;
   localparam int unsigned WAKE_DOM_TICKS = WAKE_DOM_US * 1000 / TICK_NS;
   localparam int unsigned WAKE_REC_TICKS = WAKE_REC_US * 1000 / TICK_NS;
   localparam int unsigned TXD_DOM_TICKS = TXD_DOM_US * 1000 / TICK_NS;
   localparam int unsigned TMR_W = 21;            // Timer counter width

   // Synchronised pin inputs
   localparam int unsigned NPIN = 5;
   localparam int unsigned PIN_TXD = 0;           // Transmit data
   localparam int unsigned PIN_STANDBY_SELECT_N = 1;          // standby_select_n
   localparam int unsigned PIN_BUS = 2;           // Bus dominant level
   localparam int unsigned PIN_V1UV = 3;          // regulated_supply low
   localparam int unsigned PIN_BATUV = 4;         // Battery undervoltage
   localparam logic [NPIN-1:0] PIN_RESET = 5'h19; // Safe values at reset

   // Register port
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
   localparam logic [DATA_W-1:0] CTRL_RESET = 8'h01;
   localparam int unsigned CTRL_WAKE_EN = 0;      // Wake filter enable
   localparam int unsigned CTRL_WAKE_CLR = 1;     // Write 1: clear wake

   // Transceiver states, Gray coded along the usual path
   typedef enum logic [1:0] {
      XS_OFF     = 2'b00,
      XS_OFFLINE = 2'b01,
      XS_BIAS    = 2'b11,
      XS_ACTIVE  = 2'b10
   } xcvr_state_t;

   // Wake filter phases
   typedef enum logic [1:0] {
      WK_IDLE = 2'b00,
      WK_DOM1 = 2'b01,
      WK_REC  = 2'b11,
      WK_DOM2 = 2'b10
   } wake_state_t;

endpackage : can_xcvr_pkg

/* File: inc/wake_if.sv */
// Link between the transceiver core and its wake-up pattern filter
interface wake_if;
   logic tick;     // Timebase enable pulse
   logic bus_dom;  // Synchronised bus dominant level
   logic arm;      // Filter may run
   logic hit;      // One-cycle wake detection

   modport filt (input tick, input bus_dom, input arm, output hit);
   modport core (output tick, output bus_dom, output arm, input hit);
endinterface : wake_if

/* File: core/can_wake_filter.sv */
// Standard bus wake-up pattern filter: dominant, recessive, dominant
module can_wake_filter
   import can_xcvr_pkg::*;
#(
   parameter int unsigned WINDOW_TICKS = can_xcvr_pkg::WAKE_WINDOW_TICKS,
   parameter int unsigned DOM_TICKS = can_xcvr_pkg::WAKE_DOM_TICKS,
   parameter int unsigned REC_TICKS = can_xcvr_pkg::WAKE_REC_TICKS
) (
   input wire logic clk_i,     // Core clock
   input wire logic resetn_i,  // Async reset, active low
   wake_if.filt w              // Core side link
);

   wake_state_t state_q, state_d;      // Pattern progress
   logic [TMR_W-1:0] phase_q;          // Ticks in current bus level
   logic [TMR_W-1:0] win_q;            // Ticks since first dominant
   logic level_q;                      // Bus level last cycle
   logic hit_q;                        // Registered detection

   // Phase qualification; one spare tick covers the tick phase
   wire lvl_edge = w.bus_dom ^ level_q;
   wire dom_ok = w.bus_dom && (phase_q > TMR_W'(DOM_TICKS));  // [RULE14]
   wire rec_ok = !w.bus_dom && (phase_q > TMR_W'(REC_TICKS)); // [RULE14]
   wire win_out = win_q >= TMR_W'(WINDOW_TICKS);

   assign w.hit = hit_q;

   // Phase progress; short pulses between phases only restart timing
   always_comb begin
      state_d = state_q;
      case (state_q)
         WK_IDLE: if (dom_ok) state_d = WK_DOM1;
         WK_DOM1: if (rec_ok) state_d = WK_REC;         // [RULE13]
         WK_REC:  if (dom_ok) state_d = WK_DOM2;        // [RULE13]
         WK_DOM2: state_d = WK_IDLE;
         default: state_d = WK_IDLE;
      endcase
      // Pattern must finish inside the window
      if (!w.arm || (win_out && state_q != WK_IDLE)) begin // [RULE13]
         state_d = WK_IDLE;
      end
   end

   // Timers and state
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= WK_IDLE;
         phase_q <= '0;
         win_q <= '0;
         level_q <= 1'b0;
         hit_q <= 1'b0;
      end else begin
         state_q <= state_d;
         level_q <= w.bus_dom;
         hit_q <= (state_q == WK_REC) && (state_d == WK_DOM2);
         if (lvl_edge) begin
            phase_q <= '0;
         end else if (w.tick && phase_q != '1) begin
            phase_q <= phase_q + 1'b1;
         end
         if (state_q == WK_IDLE) begin
            win_q <= '0;
         end else if (w.tick && !win_out) begin
            win_q <= win_q + 1'b1;
         end
      end
   end

endmodule : can_wake_filter

/* File: core/can_xcvr_ctrl.sv */
// CAN transceiver mode control with wake-up, status and dominant timeout

// Summary of operation
// RULE1 - Normal mode always biases bus to mid-level; code floats the bus instead in Off (battery low)
// RULE2 - Active only in Normal with supply good
// RULE3 - Low transmit on entry blocks until high
// RULE4 - Offline grounds bias and watches for wake
// RULE5 - Bus activity in Offline moves to bias
// RULE6 - Bias returns to Offline after bus silence
// RULE7 - Leaving Normal: Offline if silent, else bias
// RULE8 - Supply undervoltage moves Active to bias
// RULE9 - Leaving Off or overtemp enters Offline
// RULE10 - Wake pattern or Normal undervoltage leaves Offline
// RULE11 - Off, overtemp or battery low floats bus
// RULE12 - Off exits to Offline once conditions clear
// RULE13 - Wake needs dominant, recessive, dominant in window
// RULE14 - Each wake phase needs its least duration
// RULE15 - Detected wake drives receive output low
// RULE16 - Status high only when fully enabled
// RULE17 - Status low at startup, timeout, undervoltage
// RULE18 - Long low transmit disables transmitter
// RULE19 - Dominant timer clears on transmit high
// RULE20 - Controller keeps bit rate at least 4.4 kbit/s
// RULE21 - Floating transmit input reads as recessive
// RULE22 - Floating standby select reads as low
// RULE23 - Standby select picks Standby or Normal
// RULE24 - Timeouts are counters of a fixed timebase
module can_xcvr_ctrl
   import can_xcvr_pkg::*;
#(
   parameter int unsigned SILENCE_T = can_xcvr_pkg::SILENCE_TICKS,
   parameter int unsigned WINDOW_T = can_xcvr_pkg::WAKE_WINDOW_TICKS,
   parameter int unsigned DOM_T = can_xcvr_pkg::WAKE_DOM_TICKS,
   parameter int unsigned REC_T = can_xcvr_pkg::WAKE_REC_TICKS,
   parameter int unsigned TXD_T = can_xcvr_pkg::TXD_DOM_TICKS
) (
   input wire logic clk_i,                  // Core clock, 20 MHz
   input wire logic resetn_i,               // Async reset, active low
   // Controller pins
   input wire logic txd_i,                  // Transmit data pin
   input wire logic txd_hiz_i,              // Transmit pin undriven
   input wire logic standby_select_n_i,     // Standby select pin
   input wire logic standby_select_n_hiz_i,             // Standby pin undriven
   output logic rxd_o,                      // Receive data / wake low
   output logic cts_o,                      // Transceiver status
   // Bus side
   input wire logic bus_dom_i,              // Receiver sees dominant
   output logic tx_dom_o,                   // Drive bus dominant
   output logic rx_en_o,                    // Receiver passes data
   output logic bias_mid_o,                 // Bias bus to 2.5 V
   output logic bias_gnd_o,                 // Bias bus to ground
   output logic bus_float_o,                // Bus lines floating
   // Chip conditions
   input wire logic chip_off_i,             // Chip in Off mode
   input wire logic chip_overtemp_i,        // Chip in Overtemp mode
   input wire logic chip_reset_i,           // Chip in Reset mode
   input wire logic regulated_supply_uv_i,  // Supply below 90 %
   input wire logic bat_uv_i,               // Battery receiver undervolt
   output can_xcvr_pkg::xcvr_state_t state_o, // Transceiver state
   output logic chip_normal_o,              // Chip in Normal mode
   // Register port
   input wire logic [can_xcvr_pkg::ADDR_W-1:0] addr_i, // Byte address
   input wire logic [can_xcvr_pkg::DATA_W-1:0] wdata_i, // Write data
   input wire logic we_i,                   // Write strobe
   input wire logic re_i,                   // Read strobe
   output logic [can_xcvr_pkg::DATA_W-1:0] rdata_o // Read data
);

   import can_xcvr_pkg::*;

   // Saturating increment on a timebase tick
   function automatic logic [TMR_W-1:0] tmr_step(
      input logic [TMR_W-1:0] cnt,
      input logic tick
   );
      tmr_step = (tick && cnt != '1) ? cnt + 1'b1 : cnt;
   endfunction : tmr_step

   // Pin conditioning
   logic [NPIN-1:0] pin_raw;       // Pin levels after pull resolution
   logic [NPIN-1:0] s1_q;          // First stage, read by s2 only
   logic [NPIN-1:0] s2_q;          // Second stage
   logic [NPIN-1:0] s3_q;          // Third stage
   logic [NPIN-1:0] pin_q;         // Accepted levels

   // Pull-up on transmit, pull-down on standby select
   assign pin_raw[PIN_TXD] = txd_hiz_i ? 1'b1 : txd_i;     // [RULE21]
   assign pin_raw[PIN_STANDBY_SELECT_N] = standby_select_n_hiz_i ? 1'b0 :
                              standby_select_n_i;         // [RULE22]
   assign pin_raw[PIN_BUS] = bus_dom_i;
   assign pin_raw[PIN_V1UV] = regulated_supply_uv_i;
   assign pin_raw[PIN_BATUV] = bat_uv_i;

   // Three stage synchronisers, change taken when stages 2 and 3 agree
   generate
      for (genvar i = 0; i < NPIN; i++) begin : g_sync
         always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               s1_q[i] <= PIN_RESET[i];
               s2_q[i] <= PIN_RESET[i];
               s3_q[i] <= PIN_RESET[i];
               pin_q[i] <= PIN_RESET[i];
            end else begin
               s1_q[i] <= pin_raw[i];
               s2_q[i] <= s1_q[i];
               s3_q[i] <= s2_q[i];
               if (s2_q[i] == s3_q[i]) begin
                  pin_q[i] <= s3_q[i];
               end
            end
         end
      end
   endgenerate

   // Named conditioned levels
   wire txd_hi = pin_q[PIN_TXD];
   wire bus_dom = pin_q[PIN_BUS];
   wire v1_uv = pin_q[PIN_V1UV];
   wire batt_uv = pin_q[PIN_BATUV];

   // Timebase
   logic [TICK_W-1:0] div_q;       // Divider count
   logic tick_q;                   // One-cycle timebase enable
   // Fixed timebase for every timeout
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         div_q <= '0;
         tick_q <= 1'b0;
      end else if (div_q == TICK_W'(TICK_CYCLES - 1)) begin
         div_q <= '0;
         tick_q <= 1'b1;                                   // [RULE24]
      end else begin
         div_q <= div_q + 1'b1;
         tick_q <= 1'b0;
      end
   end

   // Chip mode and bus activity
   logic bus_prev_q;               // Bus level last cycle
   logic [TMR_W-1:0] sil_q;        // Ticks since last bus edge
   logic wake_q;                   // Wake indication pending
   logic [DATA_W-1:0] ctrl_q;      // Control register
   // Off, overtemp and reset dominate; otherwise the select line picks mode
   wire chip_dead = chip_off_i || chip_overtemp_i;
   wire normal = !chip_dead && !chip_reset_i &&
                 pin_q[PIN_STANDBY_SELECT_N];                          // [RULE23]
   wire bus_edge = bus_dom ^ bus_prev_q;
   wire silent = sil_q >= TMR_W'(SILENCE_T);

   // Bus silence timer restarts on every edge
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bus_prev_q <= 1'b0;
         sil_q <= '0;
      end else begin
         bus_prev_q <= bus_dom;
         sil_q <= bus_edge ? '0 : tmr_step(sil_q, tick_q); // [RULE24]
      end
   end

   // Wake filter
   xcvr_state_t state_q, state_d;  // Transceiver state
   wake_if wk ();                  // Link to the filter

   // Filter watches in Offline and Offline Bias when enabled
   assign wk.tick = tick_q;
   assign wk.bus_dom = bus_dom;
   assign wk.arm = (state_q == XS_OFFLINE || state_q == XS_BIAS) &&
                   ctrl_q[CTRL_WAKE_EN];                   // [RULE4] [RULE5]

   can_wake_filter #(
      .WINDOW_TICKS(WINDOW_T),
      .DOM_TICKS(DOM_T),
      .REC_TICKS(REC_T)
   ) u_wake (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .w(wk.filt)
   );

   // State machine: next state from chip mode, supplies, bus
   always_comb begin
      state_d = state_q;
      case (state_q)
         XS_OFF: begin
            // Leave only when battery and chip are back
            if (!batt_uv && !chip_dead) begin
               state_d = XS_OFFLINE;                       // [RULE12]
            end
         end
         XS_OFFLINE: begin
            if (normal && !v1_uv) begin
               state_d = XS_ACTIVE;                        // [RULE2]
            end else if (wk.hit || (normal && v1_uv)) begin
               state_d = XS_BIAS;                          // [RULE10]
            end else if (bus_edge) begin
               state_d = XS_BIAS;                          // [RULE5]
            end
         end
         XS_BIAS: begin
            if (normal && !v1_uv) begin
               state_d = XS_ACTIVE;                        // [RULE2]
            end else if (silent && !normal) begin
               state_d = XS_OFFLINE;                       // [RULE6]
            end
         end
         XS_ACTIVE: begin
            if (!normal) begin
               // Silence decides direct Offline or bias first
               state_d = silent ? XS_OFFLINE : XS_BIAS;    // [RULE7]
            end else if (v1_uv) begin
               state_d = XS_BIAS;                          // [RULE8]
            end
         end
         default: state_d = XS_OFF;
      endcase
      // Off or overtemp or battery low overrides everything
      if (chip_dead || batt_uv) begin
         state_d = XS_OFF;                                 // [RULE11]
      end
   end

   // State register; reset starts off so the bus floats
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= XS_OFF;
      end else begin
         state_q <= state_d;                               // [RULE9]
      end
   end

   // Active state guards
   logic blk_q;                    // Blocked until transmit goes high
   logic start_q;                  // Start-up done
   logic [TMR_W-1:0] dom_q;        // Transmit dominant timer
   logic dom_to_q;                 // Dominant timeout reached

   wire enter_act = (state_d == XS_ACTIVE) && (state_q != XS_ACTIVE);
   wire active = state_q == XS_ACTIVE;
   wire data_on = active && !blk_q;

   // Clamped low transmit on entry keeps data path off
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         blk_q <= 1'b0;
      end else if (enter_act) begin
         blk_q <= !txd_hi;                                 // [RULE3]
      end else if (!active || txd_hi) begin
         blk_q <= 1'b0;                                    // [RULE3]
      end
   end

   // Start-up lasts until the first timebase tick in Active
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         start_q <= 1'b0;
      end else if (!active) begin
         start_q <= 1'b0;
      end else if (tick_q) begin
         start_q <= 1'b1;
      end
   end

   // Dominant timer counts low transmit, clears on high
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dom_q <= '0;
         dom_to_q <= 1'b0;
      end else if (!data_on || txd_hi) begin
         dom_q <= '0;                                      // [RULE19]
         dom_to_q <= 1'b0;                                 // [RULE19]
      end else begin
         dom_q <= tmr_step(dom_q, tick_q);                 // [RULE18]
         if (dom_q >= TMR_W'(TXD_T)) begin
            dom_to_q <= 1'b1;                              // [RULE18]
         end
      end
   end

   // Wake indication: clear strobe from the control register
   wire wake_clr = we_i && (addr_i == REG_CTRL) &&
                   wdata_i[CTRL_WAKE_CLR];

   // Pending wake survives Off; a new detection beats a clear
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wake_q <= 1'b0;
      end else if (wk.hit) begin
         wake_q <= 1'b1;                                   // [RULE15]
      end else if (wake_clr || data_on) begin
         wake_q <= 1'b0;
      end
   end

   // Pin and bus outputs
   logic rxd_q;                    // Registered receive output
   logic cts_q;                    // Registered status output
   logic tx_dom_q;                 // Registered driver command

   // Driver and status follow the data path guards
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rxd_q <= 1'b1;
         cts_q <= 1'b0;
         tx_dom_q <= 1'b0;
      end else begin
         // Bus data when enabled, else low on a pending wake
         rxd_q <= data_on ? !bus_dom : !wake_q;            // [RULE15]
         cts_q <= data_on && start_q && !dom_to_q &&
                  !v1_uv;                                  // [RULE16] [RULE17]
         tx_dom_q <= data_on && !dom_to_q && !txd_hi;      // [RULE18]
      end
   end

   assign rxd_o = rxd_q;
   assign cts_o = cts_q;
   assign tx_dom_o = tx_dom_q;
   assign rx_en_o = data_on;

   // Bias selection; Normal keeps mid-level unless the bus floats
   assign bias_mid_o = (state_q == XS_ACTIVE) || (state_q == XS_BIAS) ||
                       (normal && state_q != XS_OFF);      // [RULE1] [RULE5]
   assign bias_gnd_o = (state_q == XS_OFFLINE) && !normal; // [RULE4]
   assign bus_float_o = state_q == XS_OFF;                 // [RULE11]
   assign state_o = state_q;
   assign chip_normal_o = normal;

   // Register port
   logic [DATA_W-1:0] rdata_q;     // Read data, one cycle after strobe
   logic [DATA_W-1:0] status;      // Live status word
   assign status = {normal, silent, blk_q, wake_q, dom_to_q, cts_q,
                    state_q};

   // Control write: only the enable bit is stored
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_q <= CTRL_RESET;
      end else if (we_i && addr_i == REG_CTRL) begin
         ctrl_q <= {{(DATA_W-1){1'b0}}, wdata_i[CTRL_WAKE_EN]};
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_q <= '0;
      end else if (re_i) begin
         case (addr_i)
            REG_CTRL:   rdata_q <= ctrl_q;
            REG_STATUS: rdata_q <= status;
            default:    rdata_q <= '0;
         endcase
      end else begin
         rdata_q <= '0;
      end
   end

   assign rdata_o = rdata_q;

endmodule : can_xcvr_ctrl

/* File: dv/can_mcu_model.sv */
// Controller model: short random bits while the data path is open
module can_mcu_model (
   input wire logic clk_i, // Core clock
   input wire logic cts_i, // Path open
   input wire logic run_i, // Send bits
   output logic txd_o      // Transmit bit
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] bit_q = 2'h0; // Cycle within a bit
   // Four-cycle bits keep the rate far above the lowest allowed
   always_ff @(posedge clk_i) begin
      bit_q <= bit_q + 2'h1;
      if (!(run_i && cts_i)) txd_o <= 1'b1; // Idle recessive
      else if (bit_q == 2'h0) txd_o <= 1'($urandom);
   end
endmodule : can_mcu_model

/* File: dv/can_xcvr_ctrl_chk.sv */
// Assertion checker for the CAN transceiver mode control
module can_xcvr_ctrl_chk
   import can_xcvr_pkg::*;
#(
   parameter int unsigned TXD_T = 30 // Dominant limit in ticks
) (
   input wire logic clk_i, resetn_i, txd_hiz_i, standby_select_n_hiz_i, // Clock, pins
   input wire logic regulated_supply_uv_i, chip_normal_o, // Supply, mode
   input wire logic cts_o, tx_dom_o, rx_en_o, bus_float_o, // Path outputs
   input wire logic bias_mid_o, bias_gnd_o, // Bias selection
   input wire can_xcvr_pkg::xcvr_state_t state_o // Transceiver state
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   localparam int DOM_MAX = (TXD_T + 3) * TICK_CYCLES; // Longest drive
   logic [15:0] dom_q; // Cycles of unbroken dominant drive
   // Run length of dominant drive
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) dom_q <= 16'h0;
      else dom_q <= tx_dom_o ? dom_q + 16'h1 : 16'h0;
   end
   property p_float; bus_float_o == (state_o == XS_OFF); endproperty
   a_float: assert property (p_float) else $error("float wrong");
   property p_gnd; state_o == XS_OFFLINE && !chip_normal_o
      |-> bias_gnd_o && !bias_mid_o; endproperty
   a_gnd: assert property (p_gnd) else $error("no ground bias");
   property p_mid; state_o == XS_BIAS || (chip_normal_o && state_o != XS_OFF)
      |-> bias_mid_o && !bias_gnd_o; endproperty
   a_mid: assert property (p_mid) else $error("no mid bias");
   property p_act; $rose(state_o == XS_ACTIVE) |-> $past(chip_normal_o);
   endproperty
   a_act: assert property (p_act) else $error("active early");
   property p_cts; cts_o |-> $past(rx_en_o); endproperty
   a_cts: assert property (p_cts) else $error("status early");
   property p_dom; dom_q <= DOM_MAX; endproperty
   a_dom: assert property (p_dom) else $error("drive too long");
   property p_txf; txd_hiz_i [*7] |-> !tx_dom_o; endproperty
   a_txf: assert property (p_txf) else $error("float drives");
   property p_stb; standby_select_n_hiz_i [*6] |-> !chip_normal_o; endproperty
   a_stb: assert property (p_stb) else $error("float normal");
   property p_uv; regulated_supply_uv_i [*8] |-> state_o != XS_ACTIVE
      && !cts_o; endproperty
   a_uv: assert property (p_uv) else $error("low supply");
endmodule : can_xcvr_ctrl_chk

bind can_xcvr_ctrl can_xcvr_ctrl_chk #(.TXD_T(TXD_T)) i_chk (.clk_i, .resetn_i,
   .txd_hiz_i, .standby_select_n_hiz_i, .regulated_supply_uv_i, .chip_normal_o, .cts_o,
   .tx_dom_o, .rx_en_o, .bus_float_o, .bias_mid_o, .bias_gnd_o, .state_o);

/* File: dv/can_transceiver_mode_control_test.sv */
// Self-checking bench of the CAN transceiver mode control
module can_transceiver_mode_control_test import can_xcvr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int SIL = 50, TXD = 30; // Shortened timeouts in ticks
   logic clk_i = 1'b0, resetn_i = 1'b0, txd_q = 1'b0, txd_hiz_i = 1'b1;
   logic standby_select_n_i = 1'b1, standby_select_n_hiz_i = 1'b1, bus_q = 1'b0;
   logic chip_off_i = 1'b0, chip_overtemp_i = 1'b0, chip_reset_i = 1'b0;
   logic regulated_supply_uv_i = 1'b0, bat_uv_i = 1'b1, run = 1'b0;
   logic we_i = 1'b0, re_i = 1'b0, mcu_txd, txd_i, bus_dom_i, rxd_o, cts_o;
   logic tx_dom_o, rx_en_o, bias_mid_o, bias_gnd_o, bus_float_o;
   logic chip_normal_o;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00, rdata_o, d;
   xcvr_state_t state_o;
   int ph[5] = '{45, 45, 3, 5, 45}; // Wake phases with a stray pulse
   int miscompares = 0, n_checks = 0, cyc_n = 0;
   assign txd_i = run ? mcu_txd : txd_q; // Controller or bench
   assign bus_dom_i = tx_dom_o | bus_q; // Own echo or far node
   always #25 clk_i = ~clk_i; // 20 MHz
   can_xcvr_ctrl #(.SILENCE_T(SIL), .WINDOW_T(100), .TXD_T(TXD)) i_dut (
      .clk_i, .resetn_i, .txd_i, .txd_hiz_i, .standby_select_n_i,
      .standby_select_n_hiz_i, .rxd_o, .cts_o, .bus_dom_i, .tx_dom_o, .rx_en_o,
      .bias_mid_o, .bias_gnd_o, .bus_float_o, .chip_off_i, .chip_overtemp_i,
      .chip_reset_i, .regulated_supply_uv_i, .bat_uv_i, .state_o,
      .chip_normal_o, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o);
   can_mcu_model i_mcu (.clk_i, .cts_i(cts_o), .run_i(run), .txd_o(mcu_txd));
   // Count and report one comparison
   task automatic chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   // Register access: write when w, else read into d
   task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] v);
      addr_i <= a;
      wdata_i <= v;
      we_i <= w;
      re_i <= !w;
      @(posedge clk_i);
      {we_i, re_i} <= 2'h0;
      @(posedge clk_i);
      d = rdata_o;
   endtask : acc
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask : cyc
   task automatic wait_cts();
      for (int i = 0; i < 200 && cts_o !== 1'b1; i++) @(posedge clk_i);
   endtask : wait_cts
   function automatic int ticks(input int t); // Cycles to outlast t ticks
      return (t + 2) * TICK_CYCLES;
   endfunction : ticks
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_sim
   // Hang guard
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n > 6000) begin
         miscompares++;
         end_sim();
      end
   end
   // Main sequence
   initial begin
      void'($urandom(32'hbd96));
      cyc(8);
      resetn_i <= 1'b1;
      acc(1'b0, REG_CTRL, 8'h00);
      chk(d === CTRL_RESET && state_o === XS_OFF, "reset");
      acc(1'b0, 4'hc, 8'h00);
      chk(d === 8'h00, "unmapped");
      bat_uv_i <= 1'b0;
      cyc(12);
      chk(state_o === XS_OFFLINE && bias_gnd_o, "offline");
      standby_select_n_hiz_i <= 1'b0;
      wait_cts();
      chk(state_o === XS_ACTIVE && cts_o, "active");
      {txd_q, txd_hiz_i, run} <= 3'h5;
      cyc(300 + $urandom_range(100));
      chk(cts_o === 1'b1, "traffic");
      {txd_q, run} <= 2'h0;
      cyc(ticks(TXD));
      acc(1'b0, REG_STATUS, 8'h00);
      chk(!tx_dom_o && !cts_o && d[3], "dominant cut");
      standby_select_n_i <= 1'b0;
      cyc(8);
      chk(state_o === XS_BIAS, "leave busy");
      standby_select_n_i <= 1'b1;
      cyc(40);
      chk(rx_en_o === 1'b0 && cts_o === 1'b0, "blocked");
      txd_q <= 1'b1;
      wait_cts();
      chk(cts_o === 1'b1, "unblocked");
      regulated_supply_uv_i <= 1'b1;
      cyc(10);
      chk(state_o === XS_BIAS && !cts_o, "supply low");
      regulated_supply_uv_i <= 1'b0;
      wait_cts();
      {chip_reset_i, standby_select_n_i} <= 2'h2;
      cyc(8);
      chk(state_o === XS_BIAS, "reset busy");
      chip_reset_i <= 1'b0;
      cyc(ticks(SIL));
      chk(state_o === XS_OFFLINE, "silence");
      foreach (ph[p]) begin
         bus_q <= ~p[0];
         cyc(ph[p] + (ph[p] > 9 ? $urandom_range(10) : 0));
      end
      bus_q <= 1'b0;
      cyc(8);
      acc(1'b0, REG_STATUS, 8'h00);
      chk(!rxd_o && state_o === XS_BIAS && d[4], "wake");
      acc(1'b1, REG_CTRL, 8'h03);
      cyc(1);
      chk(rxd_o === 1'b1, "wake clear");
      for (int k = 1; k < 3; k++) begin
         {chip_off_i, chip_overtemp_i, chip_reset_i} <= {2'(k), 1'b0};
         cyc(3);
         chk(state_o === XS_OFF && bus_float_o, "off");
         {chip_off_i, chip_overtemp_i, chip_reset_i} <= 3'h1;
         cyc(3);
         chk(state_o === XS_OFFLINE, "off exit");
      end
      end_sim();
   end
endmodule : can_transceiver_mode_control_test
